//--- verilog/mii_switch_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef MII_SWITCH_REGS_SVH
`define MII_SWITCH_REGS_SVH
// apb byte addresses
`define REG_IND_CMD 8'h00
`define REG_IND_DATA 8'h04
`define REG_PORT_SEL 8'h08
`define REG_PORT_STAT 8'h0c
// indirectly addressed mac space
`define MAC_MGMT_ACCESS 8'h06
`define MAC_MGMT_DATA 8'h07
// indirect_command fields
`define IND_BUSY_BIT 31
`define IND_RNW_BIT 30
// phy_mgmt_access fields
`define ACC_PHY_HI 15
`define ACC_PHY_LO 11
`define ACC_REG_HI 10
`define ACC_REG_LO 6
`define ACC_WNR_BIT 1
`define ACC_BUSY_BIT 0
// port_select fields and reset values
`define SEL_CLK_HI 1
`define SEL_CLK_LO 0
`define SEL_DP_BIT 2
`define CLKSEL_RESET 2'h0
`define DPSEL_RESET 1'b0
// management clock timing
`define PCLK_NS 5
`define MDC_HALF_NS 200
`define MDC_HALF_CYC ((`MDC_HALF_NS + `PCLK_NS - 1) / `PCLK_NS)
// management frame layout
`define FRAME_LAST 7'h3f
`define RD_OE_BITS 7'h2e
`define RD_DATA_FIRST 7'h30
`endif

//--- verilog/mii_switch_pkg.sv
// types for the mii port switch and management access block
package mii_switch_pkg;

	// management serial engine states
	typedef enum logic [0:0] {
		MG_IDLE,
		MG_SHIFT
	} mgmt_state_e;

	// whole state of the block
	typedef struct packed {
		logic ind_busy;
		logic ind_rnw;
		logic [7:0] ind_addr;
		logic [31:0] ind_data;
		logic [1:0] clk_sel;
		logic dp_sel;
		logic [4:0] mg_phy;
		logic [4:0] mg_reg;
		logic mg_wnr;
		logic mg_busy;
		logic [15:0] mg_data;
		mgmt_state_e st;
		logic [5:0] div;
		logic mdc;
		logic [6:0] bitn;
		logic [63:0] sh;
		logic [15:0] rsh;
		logic mdo;
		logic mdoe;
		logic [1:0][9:0] s1;
		logic [1:0][9:0] s2;
		logic m1;
		logic m2;
		logic [31:0] prdata;
		logic pslverr;
		logic mac_rxc;
		logic mac_txc;
		logic [3:0] mac_rxd;
		logic mac_dv;
		logic mac_er;
		logic mac_crs;
		logic mac_col;
		logic [3:0] itxd;
		logic iten;
		logic [3:0] etxd;
		logic eten;
	} state_s;

endpackage : mii_switch_pkg

//--- verilog/mii_port_switch_mgmt.sv
// mii port switch, clock gating and two-level phy register access
`timescale 1ns/1ps
`include "mii_switch_regs.svh"

module mii_port_switch_mgmt (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// internal phy mii
	input wire logic int_tx_clk,
	input wire logic int_rx_clk,
	input wire logic [3:0] int_rxd,
	input wire logic int_rx_dv,
	input wire logic int_rx_er,
	input wire logic int_crs,
	input wire logic int_col,
	output logic [3:0] int_txd,
	output logic int_tx_en,
	// external phy mii
	input wire logic ext_tx_clk,
	input wire logic ext_rx_clk,
	input wire logic [3:0] ext_rxd,
	input wire logic ext_rx_dv,
	input wire logic ext_rx_er,
	input wire logic ext_crs,
	input wire logic ext_col,
	output logic [3:0] ext_txd,
	output logic ext_tx_en,
	// mac side, same clock as pclk
	input wire logic [3:0] mac_txd,
	input wire logic mac_tx_en,
	output logic mac_tx_clk,
	output logic mac_rx_clk,
	output logic [3:0] mac_rxd,
	output logic mac_rx_dv,
	output logic mac_rx_er,
	output logic mac_crs,
	output logic mac_col,
	// management serial link
	output logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe
);

	////////////////////////////////////////////////////////////////
	// state and helpers

	// registered state
	mii_switch_pkg::state_s q;
	// next state
	mii_switch_pkg::state_s d;
	// apb phases
	logic setup;
	logic wr;
	// selected port bundles
	logic [9:0] dpb;
	logic [9:0] ckb;
	// clocks fully gated
	logic gated;

	// read of the indirectly addressed mac space
	function automatic logic [31:0] mac_rd(
		input mii_switch_pkg::state_s s,
		input logic [7:0] a
	);
		logic [31:0] r;
		r = 32'h0;
		// unmapped mac addresses read zero
		if (a == `MAC_MGMT_ACCESS) begin
			r[`ACC_PHY_HI:`ACC_PHY_LO] = s.mg_phy;
			r[`ACC_REG_HI:`ACC_REG_LO] = s.mg_reg;
			r[`ACC_WNR_BIT] = s.mg_wnr;
			r[`ACC_BUSY_BIT] = s.mg_busy;
		end else if (a == `MAC_MGMT_DATA) begin
			r[15:0] = s.mg_data;
		end
		return r;
	endfunction : mac_rd

	// read of the directly mapped apb registers
	function automatic logic [31:0] apb_rd(
		input mii_switch_pkg::state_s s,
		input logic [7:0] a
	);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			`REG_IND_CMD: begin
				r[`IND_BUSY_BIT] = s.ind_busy;
				r[`IND_RNW_BIT] = s.ind_rnw;
				r[7:0] = s.ind_addr;
			end
			`REG_IND_DATA: begin
				r = s.ind_data;
			end
			`REG_PORT_SEL: begin
				r[`SEL_CLK_HI:`SEL_CLK_LO] = s.clk_sel;
				r[`SEL_DP_BIT] = s.dp_sel;
			end
			`REG_PORT_STAT: begin
				// live state: gated, mgmt busy, indirect busy
				r[0] = s.clk_sel[1];
				r[1] = s.mg_busy;
				r[2] = s.ind_busy;
			end
			default: begin
				r = 32'h0;
			end
		endcase
		return r;
	endfunction : apb_rd

	// address decode for the error path only, apb_rd decodes reads itself
	function automatic logic mapped(input logic [7:0] a);
		return (a == `REG_IND_CMD) || (a == `REG_IND_DATA) ||
			(a == `REG_PORT_SEL) || (a == `REG_PORT_STAT);
	endfunction : mapped

	////////////////////////////////////////////////////////////////
	// next-state logic

	// whole block in one combinational pass
	always_comb begin
		d = q;
		setup = psel & ~penable;
		wr = psel & penable & pwrite;

		// two-flop synchronisers for every pin from the phys
		d.s1[0] = {int_tx_clk, int_rx_clk, int_rxd, int_rx_dv,
			int_rx_er, int_crs, int_col};
		d.s1[1] = {ext_tx_clk, ext_rx_clk, ext_rxd, ext_rx_dv,
			ext_rx_er, ext_crs, ext_col};
		d.s2 = q.s1;
		d.m1 = mdio_i;
		d.m2 = q.m1;

		dpb = q.s2[q.dp_sel];
		d.mac_rxd = dpb[7:4];
		d.mac_dv = dpb[3];
		d.mac_er = dpb[2];
		d.mac_crs = dpb[1];
		d.mac_col = dpb[0];
		// transmit side routing
		// deselected port is driven idle, never floating
		d.itxd = q.dp_sel ? 4'h0 : mac_txd;
		d.iten = q.dp_sel ? 1'b0 : mac_tx_en;
		d.etxd = q.dp_sel ? mac_txd : 4'h0;
		d.eten = q.dp_sel ? mac_tx_en : 1'b0;

		// gate both phy clocks when select is 10b
		// 11b is treated the same, so no stray clock leaks
		gated = q.clk_sel[1];
		ckb = q.s2[q.clk_sel[0]];
		// gated clocks held low, mac sees no edges
		d.mac_txc = ~gated & ckb[9];
		d.mac_rxc = ~gated & ckb[8];

		// apb read data and error latched in setup phase
		if (setup) begin
			d.prdata = apb_rd(q, paddr);
			d.pslverr = ~mapped(paddr);
		end

		// indirect transfer, one cycle after issue
		if (q.ind_busy) begin
			if (q.ind_rnw) begin
				d.ind_data = mac_rd(q, q.ind_addr);
			end else if (q.ind_addr == `MAC_MGMT_DATA) begin
				// only low half reaches the phy data
				// a write during a phy cycle is left out
				if (!q.mg_busy) begin
					d.mg_data = q.ind_data[15:0];
				end
			end else if (q.ind_addr == `MAC_MGMT_ACCESS) begin
				if (!q.mg_busy) begin
					d.mg_phy = q.ind_data[`ACC_PHY_HI:`ACC_PHY_LO];
					d.mg_reg = q.ind_data[`ACC_REG_HI:`ACC_REG_LO];
					d.mg_wnr = q.ind_data[`ACC_WNR_BIT];
				end
				// busy written 1 starts a frame
				if (!q.mg_busy && q.ind_data[`ACC_BUSY_BIT]) begin
					d.mg_busy = 1'b1;
					d.st = mii_switch_pkg::MG_SHIFT;
					d.div = 6'h0;
					d.mdc = 1'b0;
					d.bitn = 7'h0;
					// preamble, start, op, addresses, turnaround, data
					d.sh = {32'hffffffff, 2'b01,
						q.ind_data[`ACC_WNR_BIT] ? 2'b01 : 2'b10,
						q.ind_data[`ACC_PHY_HI:`ACC_PHY_LO],
						q.ind_data[`ACC_REG_HI:`ACC_REG_LO],
						2'b10, q.mg_data};
					d.mdo = 1'b1;
					d.mdoe = 1'b1;
				end
			end
			d.ind_busy = 1'b0;
		end

		// apb writes take effect at the access edge
		if (wr) begin
			case (paddr)
				`REG_IND_CMD: begin
					// address, direction and busy in one write
					// reserved span is dropped
					// a command while busy would be spurious
					if (!q.ind_busy) begin
						d.ind_busy = pwdata[`IND_BUSY_BIT];
						d.ind_rnw = pwdata[`IND_RNW_BIT];
						d.ind_addr = pwdata[7:0];
					end
				end
				`REG_IND_DATA: begin
					// data must not move under a transfer
					if (!q.ind_busy) begin
						d.ind_data = pwdata;
					end
				end
				`REG_PORT_SEL: begin
					d.clk_sel = pwdata[`SEL_CLK_HI:`SEL_CLK_LO];
					d.dp_sel = pwdata[`SEL_DP_BIT];
				end
				default: begin
					// read-only and unmapped writes ignored
				end
			endcase
		end

		// management serial engine
		case (q.st)
			mii_switch_pkg::MG_IDLE: begin
				// a frame starting this cycle keeps its drive, else bit 0 is lost
				if (d.st != mii_switch_pkg::MG_SHIFT) begin
					d.mdoe = 1'b0;
					d.mdc = 1'b0;
				end
			end
			mii_switch_pkg::MG_SHIFT: begin
				// half period divider gives the mdc edges
				if (q.div == 6'(`MDC_HALF_CYC - 1)) begin
					d.div = 6'h0;
					d.mdc = ~q.mdc;
					if (!q.mdc) begin
						// rising edge: phy drives data on reads
						if (!q.mg_wnr && q.bitn >= `RD_DATA_FIRST) begin
							d.rsh = {q.rsh[14:0], q.m2};
						end
					end else if (q.bitn == `FRAME_LAST) begin
						// busy held to the end of the frame
						d.st = mii_switch_pkg::MG_IDLE;
						d.mg_busy = 1'b0;
						d.mdoe = 1'b0;
						// read result lands in mgmt data
						if (!q.mg_wnr) begin
							d.mg_data = q.rsh;
						end
					end else begin
						// falling edge: next bit out
						d.bitn = q.bitn + 7'h1;
						d.sh = {q.sh[62:0], 1'b0};
						d.mdo = q.sh[62];
						// reads release the line at turnaround
						d.mdoe = q.mg_wnr ||
							((q.bitn + 7'h1) < `RD_OE_BITS);
					end
				end else begin
					d.div = q.div + 6'h1;
				end
			end
			default: begin
				d.st = mii_switch_pkg::MG_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state register

	// single register stage, constants only under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.clk_sel <= `CLKSEL_RESET;
			q.dp_sel <= `DPSEL_RESET;
			q.st <= mii_switch_pkg::MG_IDLE;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	// zero wait states, answer always ready
	assign pready = 1'b1;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	// mii outputs straight from flops
	assign int_txd = q.itxd;
	assign int_tx_en = q.iten;
	assign ext_txd = q.etxd;
	assign ext_tx_en = q.eten;
	assign mac_tx_clk = q.mac_txc;
	assign mac_rx_clk = q.mac_rxc;
	assign mac_rxd = q.mac_rxd;
	assign mac_rx_dv = q.mac_dv;
	assign mac_rx_er = q.mac_er;
	assign mac_crs = q.mac_crs;
	assign mac_col = q.mac_col;
	// management link
	assign mdc = q.mdc;
	assign mdio_o = q.mdo;
	assign mdio_oe = q.mdoe;

endmodule : mii_port_switch_mgmt

//--- sim/mii_phy_model.sv
// behavioural model of the internal and external phys
`timescale 1ns/1ps
module mii_phy_model (
	output logic int_tx_clk,
	output logic int_rx_clk,
	output logic [3:0] int_rxd,
	output logic int_rx_dv,
	output logic int_rx_er,
	output logic int_crs,
	output logic int_col,
	output logic ext_tx_clk,
	output logic ext_rx_clk,
	output logic [3:0] ext_rxd,
	output logic ext_rx_dv,
	output logic ext_rx_er,
	output logic ext_crs,
	output logic ext_col,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	output logic mdio_i,
	output logic [63:0] frame
);
	initial begin
		int_tx_clk = 1'b0;
		forever #24 int_tx_clk = ~int_tx_clk;
	end
	initial begin
		ext_tx_clk = 1'b0;
		forever #24 ext_tx_clk = ~ext_tx_clk;
	end
	assign int_rx_clk = ~int_tx_clk;
	assign ext_rx_clk = ~ext_tx_clk;
	// distinct levels per port so routing shows
	assign int_rxd = 4'h5;
	assign ext_rxd = 4'ha;
	assign int_rx_dv = 1'b1;
	assign ext_rx_dv = 1'b0;
	assign int_rx_er = 1'b0;
	assign ext_rx_er = 1'b1;
	assign int_crs = 1'b1;
	assign ext_crs = 1'b0;
	assign int_col = 1'b0;
	assign ext_col = 1'b1;
	// no phy answers: pull-up reads all ones
	assign mdio_i = mdio_oe ? mdio_o : 1'b1;
	// capture driven bits on each mdc rise
	initial frame = 64'h0;
	always @(posedge mdc) begin
		if (mdio_oe) begin
			frame <= {frame[62:0], mdio_o};
		end
	end
endmodule : mii_phy_model

//--- sim/mii_switch_chk.sv
// concurrent checks on the mii port switch ports
`timescale 1ns/1ps
module mii_switch_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic int_tx_en,
	input wire logic ext_tx_en,
	input wire logic mac_tx_clk,
	input wire logic mac_rx_clk,
	input wire logic mdc,
	input wire logic mdio_o,
	input wire logic mdio_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// port select write at its access edge
	wire logic wr_sel = psel && penable && pwrite && paddr == 8'h08;
	// setup cycle of any transfer
	wire logic setup = psel && !penable;
	// datapath port as last written, for the transmit routing checks
	logic dp_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dp_q <= 1'b0;
		end else if (wr_sel) begin
			dp_q <= pwdata[2];
		end
	end
	tx_int_port_a: assert property (int_tx_en |-> !$past(dp_q)) else $error("int tx on ext");
	tx_ext_port_a: assert property (ext_tx_en |-> $past(dp_q)) else $error("ext tx on int");
	no_wait_a: assert property (psel |-> pready) else $error("pready low");
	bad_addr_a: assert property (setup && paddr > 8'h0c |=> pslverr) else $error("no pslverr");
	good_addr_a: assert property (setup && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0
		|=> !pslverr) else $error("pslverr on mapped");
	clk_gated_a: assert property (wr_sel && pwdata[1] |-> ##4
		(!mac_tx_clk && !mac_rx_clk)[*8]) else $error("clock not gated");
	tx_route_a: assert property (wr_sel ##4 1 |->
		($past(pwdata[2], 4) ? !int_tx_en : !ext_tx_en)) else $error("tx misrouted");
	mdc_half_a: assert property ($rose(mdc) |-> ##40 $fell(mdc)) else $error("mdc high time");
	mdc_low_a: assert property ($fell(mdc) |-> !mdc[*8]) else $error("mdc low time");
	mdo_edge_a: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_o)
		|-> $fell(mdc)) else $error("mdio moved off mdc fall");
	oe_start_a: assert property ($rose(mdio_oe) |-> !mdc) else $error("frame starts high");
	cover property (wr_sel && pwdata[1]);
	cover property ($rose(mdio_oe));
	cover property (setup && paddr > 8'h0c);
endmodule : mii_switch_chk
bind mii_port_switch_mgmt mii_switch_chk mii_switch_chk_inst (.*);

//--- sim/mii_port_switch_mgmt_access_bench.sv
// self-checking bench for the mii port switch block
`timescale 1ns/1ps
module mii_port_switch_mgmt_access_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] int_rxd, ext_rxd, int_txd, ext_txd, mac_txd, mac_rxd;
	logic int_tx_clk, int_rx_clk, int_rx_dv, int_rx_er, int_crs, int_col;
	logic ext_tx_clk, ext_rx_clk, ext_rx_dv, ext_rx_er, ext_crs, ext_col;
	logic int_tx_en, ext_tx_en, mac_tx_en, mac_tx_clk, mac_rx_clk, mac_rx_dv;
	logic mac_rx_er, mac_crs, mac_col, mdc, mdio_i, mdio_o, mdio_oe, seen;
	logic [63:0] frame;
	int miscompares, n_tests;
	mii_port_switch_mgmt mii_port_switch_mgmt_inst (.*);
	mii_phy_model mii_phy_model_inst (.*);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// compare and count
	task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer, then one idle edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
		rd = prdata;
		err = pslverr;
		if (n > 20) miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// indirect command, polled until busy drops
	task automatic ind(input logic rnw, input logic [7:0] a);
		int n;
		n = 0;
		apb(1'b1, 8'h00, {1'b1, rnw, 22'h0, a});
		do apb(1'b0, 8'h00, 32'h0); while (rd[31] !== 1'b0 && n++ < 20);
		if (n > 20) miscompares++;
	endtask : ind
	// phy access through the access register, polled on its busy bit
	task automatic mg(input logic [31:0] acc);
		int n;
		n = 0;
		apb(1'b1, 8'h04, acc);
		ind(1'b0, 8'h06);
		do begin
			ind(1'b1, 8'h06);
			apb(1'b0, 8'h04, 32'h0);
		end while (rd[0] !== 1'b0 && n++ < 1000);
		if (n > 1000) miscompares++;
	endtask : mg
	task automatic report_and_stop;
		if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// hang guard, well beyond three frames
	initial begin
		#400000;
		miscompares++;
		report_and_stop();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, mac_txd, mac_tx_en} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		chk("port select reset", rd, 64'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped", {err, rd}, {1'b1, 32'h0});
		// only the low half reaches the data register
		apb(1'b1, 8'h04, 32'hcafe01e1);
		ind(1'b0, 8'h07);
		apb(1'b1, 8'h04, 32'h0);
		ind(1'b1, 8'h07);
		apb(1'b0, 8'h04, 32'h0);
		chk("mgmt data", rd, 64'h01e1);
		mg({16'h0, 5'd2, 5'd4, 4'h0, 2'b11});
		chk("write frame", frame, {32'hffffffff, 4'b0101, 5'd2, 5'd4, 2'b10, 16'h01e1});
		mg({16'h0, 5'd3, 5'd1, 4'h0, 2'b01});
		chk("read frame", frame[45:0], {32'hffffffff, 4'b0110, 5'd3, 5'd1});
		ind(1'b1, 8'h07);
		apb(1'b0, 8'h04, 32'h0);
		chk("phy read", rd, 64'hffff);
		mac_txd <= 4'h9;
		// same steps each way: halt, gate, wait, route, reselect, enable
		for (int p = 1; p >= 0; p--) begin
			// transmitter halted before any select change
			mac_tx_en <= 1'b0;
			// receiver halt lives in the mac, nothing to drive here
			apb(1'b1, 8'h08, {29'h0, ~p[0], 2'b10});
			repeat (50) @(posedge pclk);
			chk("gated", {mac_tx_clk, mac_rx_clk}, 64'h0);
			apb(1'b0, 8'h0c, 32'h0);
			chk("status gated", rd, 64'h1);
			apb(1'b1, 8'h08, {29'h0, p[0], 2'b10});
			repeat (20) @(posedge pclk);
			apb(1'b1, 8'h08, {29'h0, p[0], 1'b0, p[0]});
			repeat (50) @(posedge pclk);
			// transmitter back only after the wait
			mac_tx_en <= 1'b1;
			repeat (4) @(posedge pclk);
			chk("route", {mac_rx_dv, mac_rxd, mac_rx_er, mac_crs, mac_col, int_tx_en,
				int_txd, ext_tx_en, ext_txd}, p ? 64'h15419 : 64'h2ab20);
			seen = 1'b0;
			repeat (30) @(posedge pclk) seen |= mac_tx_clk;
			chk("clock back", seen, 64'h1);
		end
		report_and_stop();
	end
endmodule : mii_port_switch_mgmt_access_bench
